// [cis_core_irq.sv]
// Interrupt sources, sleep and wake sequencing, return stack, bus slave
//
// Summary of operation
// - The external edge is rising when polarity select is one, else falling.
// - A valid external edge sets the external flag at bit 1 of control.
// - Clearing the external enable blocks its request; the flag still sets.
// - The external pin wakes from sleep only if enabled before sleep entry.
// - After wake-up the vector is taken only with the global enable set.
// - A timer wrap from FF to 00 sets the timer flag at bit 2 of control.
// - The timer request reaches the core only with its enable at bit 5 set.
// - A level change on any upper port pin sets the port flag at bit 0.
// - The port change request reaches the core only with its enable set.
// - Taking an interrupt pushes only the return program counter.
// - Sleep ends on reset, watchdog wake-up or an enabled interrupt.
`timescale 1ns/100ps
`default_nettype none
module cis_core_irq
(
    input  wire logic                         clk_i,
    input  wire logic                         rst_i,
    input  wire logic                         wb_cyc_i,
    input  wire logic                         wb_stb_i,
    input  wire logic                         wb_we_i,
    input  wire logic [7:0]                   wb_adr_i,
    input  wire logic [3:0]                   wb_sel_i,
    input  wire logic [31:0]                  wb_dat_i,
    output logic      [31:0]                  wb_dat_o,
    output logic                              wb_ack_o,
    input  wire logic                         ext_irq_pin_i,
    input  wire logic [cis_pkg::PORT_W-1:0]   upper_port_i,
    input  wire logic                         sleep_i,
    input  wire logic                         wdt_wake_i,
    input  wire logic                         return_i,
    input  wire logic [cis_pkg::PC_W-1:0]     core_pc_i,
    output logic                              irq_req_o,
    output logic                              vector_o,
    output logic                              wake_o,
    output logic                              sleeping_o,
    output logic                              int_o
);
    typedef struct packed
    {
        cis_pkg::cis_state_t                               state;
        logic [7:0]                                        ctrl;
        logic [7:0]                                        opt;
        logic [7:0]                                        tmr;
        logic [cis_pkg::DIV_W-1:0]                         div;
        logic                                              sleep_ext_en;
        logic [cis_pkg::STK_D-1:0][cis_pkg::PC_W-1:0]      stk;
        logic [cis_pkg::SP_W-1:0]                          sp;
        logic [cis_pkg::EVT_W-1:0]                         evt;
        logic [cis_pkg::EVT_W-1:0]                         mask;
        logic                                              ack;
        logic [31:0]                                       rdat;
        logic                                              irq_req;
        logic                                              vector;
        logic                                              wake;
        logic                                              asleep;
        logic                                              irq;
    } cis_top_st_t;

    cis_top_st_t              s;
    cis_top_st_t              next_s;
    logic                     ext_pulse;
    logic                     chg_pulse;
    logic                     wr;
    logic                     tick;
    logic                     ovf;
    logic                     pend;
    logic                     wake_ev;
    logic [cis_pkg::EVT_W-1:0] ev;
    logic [cis_pkg::PC_W-1:0] top;

    // Address match for a bus offset
    function automatic logic hit(input logic [7:0] adr,
                                 input logic [7:0] off);
        hit = (adr[7:2] == off[7:2]);
    endfunction : hit

    cis_edge_det u_edge
    (
        .clk_i         (clk_i),
        .rst_i         (rst_i),
        .ext_irq_pin_i (ext_irq_pin_i),
        .rising_i      (s.opt[cis_pkg::OPT_EDGE]),
        .edge_o        (ext_pulse)
    );

    cis_chg_det u_chg
    (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .upper_port_i (upper_port_i),
        .chg_o        (chg_pulse)
    );

    // Top of the return stack
    assign top = s.stk[s.sp - cis_pkg::SP_W'(1)];

    // Next-state logic
    always_comb
    begin
        next_s = s;
        ev = '0;
        // Bus handshake: ack one cycle after the request, dropped after
        next_s.ack = wb_cyc_i & wb_stb_i & ~s.ack;
        wr = next_s.ack & wb_we_i & wb_sel_i[0];
        next_s.rdat = '0;
        if (next_s.ack & ~wb_we_i)
        begin
            if (hit(wb_adr_i, cis_pkg::ADR_CTRL))
                next_s.rdat = {24'h000000, s.ctrl};
            else if (hit(wb_adr_i, cis_pkg::ADR_OPT))
                next_s.rdat = {24'h000000, s.opt};
            else if (hit(wb_adr_i, cis_pkg::ADR_TMR))
                next_s.rdat = {24'h000000, s.tmr};
            else if (hit(wb_adr_i, cis_pkg::ADR_PORT))
                next_s.rdat = {24'h000000, upper_port_i, 4'h0};
            else if (hit(wb_adr_i, cis_pkg::ADR_STAT))
                next_s.rdat = {25'h0000000, s.sp, 1'b0, s.state};
            else if (hit(wb_adr_i, cis_pkg::ADR_EVT))
                next_s.rdat = {29'h00000000, s.evt};
            else if (hit(wb_adr_i, cis_pkg::ADR_MASK))
                next_s.rdat = {29'h00000000, s.mask};
            else if (hit(wb_adr_i, cis_pkg::ADR_STK))
                next_s.rdat = {19'h00000, top};
        end
        // Instruction-cycle tick for the timer
        tick = (s.div == cis_pkg::DIV_W'(cis_pkg::TICK_CYC - 1));
        next_s.div = tick ? '0 : s.div + cis_pkg::DIV_W'(1);
        ovf = 1'b0;
        if (wr && hit(wb_adr_i, cis_pkg::ADR_TMR))
            next_s.tmr = wb_dat_i[7:0];
        else if (tick)
        begin
            next_s.tmr = s.tmr + 8'h01;
            ovf = (s.tmr == cis_pkg::TMR_MAX);
        end
        // Control and option writes
        if (wr && hit(wb_adr_i, cis_pkg::ADR_CTRL))
            next_s.ctrl = wb_dat_i[7:0];
        if (wr && hit(wb_adr_i, cis_pkg::ADR_OPT))
            next_s.opt = wb_dat_i[7:0];
        // Flags record regardless of enables; hardware set wins
        if (ovf)
            next_s.ctrl[cis_pkg::CTL_TMR_FLAG] = 1'b1;
        if (ext_pulse)
            next_s.ctrl[cis_pkg::CTL_EXT_FLAG] = 1'b1;
        if (chg_pulse)
            next_s.ctrl[cis_pkg::CTL_PCH_FLAG] = 1'b1;
        // Enabled source pending: enables 5..3 pair with flags 2..0
        pend = |(s.ctrl[5:3] & s.ctrl[2:0]);
        next_s.irq_req = s.ctrl[cis_pkg::CTL_GIE] & pend;
        wake_ev = wdt_wake_i
                | (s.ctrl[cis_pkg::CTL_EXT_FLAG] & s.sleep_ext_en)
                | (s.ctrl[cis_pkg::CTL_TMR_FLAG]
                   & s.ctrl[cis_pkg::CTL_TMR_EN])
                | (s.ctrl[cis_pkg::CTL_PCH_FLAG]
                   & s.ctrl[cis_pkg::CTL_PCH_EN]);
        next_s.vector = 1'b0;
        next_s.wake = 1'b0;
        // Return pops the stack
        if (return_i)
            next_s.sp = s.sp - cis_pkg::SP_W'(1);
        // Sleep, wake and vector sequencing
        case (s.state)
            cis_pkg::ST_RUN:
            begin
                if (sleep_i)
                begin
                    next_s.state = cis_pkg::ST_SLEEP;
                    next_s.sleep_ext_en = s.ctrl[cis_pkg::CTL_EXT_EN];
                end
                else if (s.ctrl[cis_pkg::CTL_GIE] && pend && !return_i)
                begin
                    next_s.vector = 1'b1;
                    next_s.stk[s.sp] = core_pc_i;
                    next_s.sp = s.sp + cis_pkg::SP_W'(1);
                    next_s.ctrl[cis_pkg::CTL_GIE] = 1'b0;
                    ev[cis_pkg::EVT_VEC] = 1'b1;
                    ev[cis_pkg::EVT_WRAP] =
                        (s.sp == cis_pkg::SP_W'(cis_pkg::STK_D - 1));
                end
            end
            cis_pkg::ST_SLEEP:
            begin
                if (wake_ev)
                begin
                    next_s.state = cis_pkg::ST_WAKE;
                    next_s.wake = 1'b1;
                    ev[cis_pkg::EVT_WAKE] = 1'b1;
                end
            end
            cis_pkg::ST_WAKE:
                next_s.state = cis_pkg::ST_RUN;
            default:
                next_s.state = cis_pkg::ST_RUN;
        endcase
        next_s.asleep = (next_s.state == cis_pkg::ST_SLEEP);
        // Sticky events: write one clears, a new event wins
        if (wr && hit(wb_adr_i, cis_pkg::ADR_EVT))
            next_s.evt = s.evt & ~wb_dat_i[cis_pkg::EVT_W-1:0];
        next_s.evt = next_s.evt | ev;
        if (wr && hit(wb_adr_i, cis_pkg::ADR_MASK))
            next_s.mask = wb_dat_i[cis_pkg::EVT_W-1:0];
        next_s.irq = |(next_s.evt & next_s.mask);
    end

    // State register; reset also ends sleep
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s <= '0;
            s.state <= cis_pkg::ST_RUN;
            s.ctrl <= cis_pkg::CTRL_RST;
            s.opt <= cis_pkg::OPT_RST;
            s.tmr <= cis_pkg::TMR_RST;
            s.evt <= cis_pkg::EVT_RST;
        end
        else
            s <= next_s;
    end

    // Outputs straight from the state register
    assign wb_dat_o   = s.rdat;
    assign wb_ack_o   = s.ack;
    assign irq_req_o  = s.irq_req;
    assign vector_o   = s.vector;
    assign wake_o     = s.wake;
    assign sleeping_o = s.asleep;
    assign int_o      = s.irq;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Steps after a wake-up
    sequence s_wake_gie;
        s.state == cis_pkg::ST_WAKE && s.ctrl[cis_pkg::CTL_GIE] && pend
            && !wr;
    endsequence
    sequence s_wake_nogie;
        s.state == cis_pkg::ST_WAKE && !s.ctrl[cis_pkg::CTL_GIE]
            && !wr;
    endsequence

    AST_EXT_FLAG: assert property (ext_pulse |=>
        s.ctrl[cis_pkg::CTL_EXT_FLAG])
        else $error("external edge did not set its flag");

    AST_TMR_FLAG: assert property (ovf |=>
        s.ctrl[cis_pkg::CTL_TMR_FLAG] && s.tmr == 8'h00)
        else $error("timer wrap did not set its flag");

    AST_PCH_FLAG: assert property (chg_pulse |=>
        s.ctrl[cis_pkg::CTL_PCH_FLAG])
        else $error("port change did not set its flag");

    AST_EXT_BLOCK: assert property (!s.ctrl[4]
        && !(s.ctrl[5] && s.ctrl[2])
        && !(s.ctrl[3] && s.ctrl[0]) |=> !irq_req_o)
        else $error("request without an enabled source");

    AST_TMR_GATE: assert property (s.ctrl[cis_pkg::CTL_TMR_FLAG]
        && !s.ctrl[cis_pkg::CTL_TMR_EN] && !(s.ctrl[4] && s.ctrl[1])
        && !(s.ctrl[3] && s.ctrl[0]) |=> !irq_req_o)
        else $error("timer request passed with its enable clear");

    AST_PCH_GATE: assert property (s.ctrl[cis_pkg::CTL_PCH_FLAG]
        && !s.ctrl[cis_pkg::CTL_PCH_EN] && !(s.ctrl[4] && s.ctrl[1])
        && !(s.ctrl[5] && s.ctrl[2]) |=> !irq_req_o)
        else $error("port request passed with its enable clear");

    AST_REQ: assert property (s.ctrl[cis_pkg::CTL_GIE] && pend
        |=> irq_req_o)
        else $error("enabled pending source not requested");

    AST_WAKE_EXT: assert property (s.state == cis_pkg::ST_SLEEP
        && !s.sleep_ext_en && !wdt_wake_i && !(s.ctrl[5] && s.ctrl[2])
        && !(s.ctrl[3] && s.ctrl[0]) |=> s.state == cis_pkg::ST_SLEEP)
        else $error("woke on pin with enable clear at sleep entry");

    AST_WAKE_WDT: assert property (s.state == cis_pkg::ST_SLEEP
        && wdt_wake_i |=> wake_o ##1 s.state == cis_pkg::ST_RUN)
        else $error("watchdog wake-up not honoured");

    AST_VEC_GIE: assert property (s_wake_gie ##1 !sleep_i && !return_i
        |=> vector_o)
        else $error("no vector after wake with global enable");

    AST_VEC_NOGIE: assert property (s_wake_nogie |=>
        !vector_o [*2])
        else $error("vector taken with global enable clear");

    AST_PUSH: assert property (vector_o |->
        top == $past(core_pc_i) && s.sp == $past(s.sp) + 3'h1)
        else $error("return address not pushed on vector");

endmodule : cis_core_irq
`default_nettype wire

// [cis_pkg.sv]
// Constants, register map and state codes of the interrupt source block
package cis_pkg;

    // Register byte offsets on the bus
    localparam logic [7:0] ADR_CTRL = 8'h00; // irq_control_reg
    localparam logic [7:0] ADR_OPT  = 8'h04; // option bits
    localparam logic [7:0] ADR_TMR  = 8'h08; // timer_zero_count
    localparam logic [7:0] ADR_PORT = 8'h0C; // upper_port levels
    localparam logic [7:0] ADR_STAT = 8'h10; // core state and stack depth
    localparam logic [7:0] ADR_EVT  = 8'h14; // sticky events, write 1 clears
    localparam logic [7:0] ADR_MASK = 8'h18; // event mask
    localparam logic [7:0] ADR_STK  = 8'h1C; // top of return stack

    // Fields of irq_control_reg
    localparam int CTL_GIE      = 7;
    localparam int CTL_TMR_EN   = 5;
    localparam int CTL_EXT_EN   = 4;
    localparam int CTL_PCH_EN   = 3;
    localparam int CTL_TMR_FLAG = 2;
    localparam int CTL_EXT_FLAG = 1;
    localparam int CTL_PCH_FLAG = 0;

    // Field of option register
    localparam int OPT_EDGE = 6;

    // Sticky event bits
    localparam int EVT_W    = 3;
    localparam int EVT_VEC  = 0;
    localparam int EVT_WAKE = 1;
    localparam int EVT_WRAP = 2;

    // Reset values
    localparam logic [7:0]       CTRL_RST = 8'h00;
    localparam logic [7:0]       OPT_RST  = 8'h40;
    localparam logic [7:0]       TMR_RST  = 8'h00;
    localparam logic [EVT_W-1:0] EVT_RST  = 3'h0;

    // Timer and stack
    localparam logic [7:0] TMR_MAX = 8'hFF;
    localparam int         PC_W    = 13;
    localparam int         STK_D   = 8;
    localparam int         SP_W    = 3;
    localparam int         PORT_W  = 4;

    // Timer tick: one instruction cycle of 400 ns
    localparam int CLK_HZ   = 10_000_000;
    localparam int TICK_NS  = 400;
    localparam int TICK_CYC = (TICK_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int DIV_W    = 2;

    // Core sequencing states
    typedef enum logic [2:0]
    {
        ST_RUN   = 3'b001,
        ST_SLEEP = 3'b010,
        ST_WAKE  = 3'b100
    } cis_state_t;

endpackage : cis_pkg

// [cis_edge_det.sv]
// Polarity-selectable edge detector for the external interrupt pin
`timescale 1ns/100ps
`default_nettype none
module cis_edge_det
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ext_irq_pin_i,
    input  wire logic rising_i,
    output logic      edge_o
);
    typedef struct packed
    {
        logic prev;
        logic pulse;
        logic armed;
    } cis_edge_st_t;

    cis_edge_st_t s;
    cis_edge_st_t next_s;

    // Pick the edge direction from the polarity select
    always_comb
    begin
        next_s = s;
        next_s.prev = ext_irq_pin_i;
        next_s.armed = 1'b1;
        next_s.pulse = rising_i ? (ext_irq_pin_i & ~s.prev)
                                : (~ext_irq_pin_i & s.prev);
        // Prev holds no pin level yet in the first cycle after reset
        next_s.pulse = next_s.pulse & s.armed;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            s <= '0;
        else
            s <= next_s;
    end

    assign edge_o = s.pulse;

    AST_EDGE_POL: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 $past(rst_i, 2) == 1'b0 |-> edge_o == ($past(rising_i)
            ? ($past(ext_irq_pin_i) && !$past(ext_irq_pin_i, 2))
            : (!$past(ext_irq_pin_i) && $past(ext_irq_pin_i, 2))))
        else $error("edge pulse does not match selected polarity");

endmodule : cis_edge_det
`default_nettype wire

// [cis_chg_det.sv]
// Level change detector for the upper four port pins
`timescale 1ns/100ps
`default_nettype none
module cis_chg_det
(
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    input  wire logic [cis_pkg::PORT_W-1:0] upper_port_i,
    output logic                           chg_o
);
    typedef struct packed
    {
        logic [cis_pkg::PORT_W-1:0] prev;
        logic                       pulse;
        logic                       armed;
    } cis_chg_st_t;

    cis_chg_st_t                s;
    cis_chg_st_t                next_s;
    logic [cis_pkg::PORT_W-1:0] diff;

    // One comparator per pin
    genvar g;
    generate
        for (g = 0; g < cis_pkg::PORT_W; g++)
        begin : g_pin
            assign diff[g] = upper_port_i[g] ^ s.prev[g];
        end
    endgenerate

    // Any pin that moved raises one pulse
    always_comb
    begin
        next_s = s;
        next_s.prev = upper_port_i;
        next_s.armed = 1'b1;
        // No change in the first cycle after reset: pins may idle high
        next_s.pulse = (|diff) & s.armed;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            s <= '0;
        else
            s <= next_s;
    end

    assign chg_o = s.pulse;

endmodule : cis_chg_det
`default_nettype wire

// [cis_core_model.sv]
// Behavioural processor core facing the interrupt source block
`timescale 1ns/100ps
`default_nettype none
module cis_core_model
(
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   vector_i,
    input  wire logic                   slow_i,
    input  wire logic                   sleep_cmd_i,
    output logic                        sleep_o,
    output logic                        return_o,
    output logic [cis_pkg::PC_W-1:0]    pc_o,
    output logic [7:0]                  vec_cnt_o
);
    logic [5:0] wait_cnt;
    logic       busy;

    // Handler runs a short or long time, then returns and moves the PC on
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sleep_o   <= 1'b0;
            return_o  <= 1'b0;
            pc_o      <= 13'h0ABC;
            vec_cnt_o <= 8'h00;
            wait_cnt  <= 6'h00;
            busy      <= 1'b0;
        end
        else
        begin
            sleep_o  <= sleep_cmd_i;
            return_o <= 1'b0;
            if (vector_i)
            begin
                busy      <= 1'b1;
                wait_cnt  <= slow_i ? 6'h1E : 6'h02;
                vec_cnt_o <= vec_cnt_o + 8'h01;
            end
            else if (busy && wait_cnt == 6'h00)
            begin
                busy     <= 1'b0;
                return_o <= 1'b1;
                pc_o     <= pc_o + 13'h0111; // New PC with the return pulse, a cycle before the pop
            end
            else if (busy)
            begin
                wait_cnt <= wait_cnt - 6'h01;
            end
        end
    end
endmodule : cis_core_model
`default_nettype wire

// [cis_core_irq_tb_top.sv]
// Self-checking bench of the interrupt source block with a core model
`timescale 1ns/100ps
`default_nettype none
`define CIS_CHK(what, exp, got) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) \
        begin \
            $display("wrong value %s exp %0h got %0h", what, exp, got); \
            failures++; \
        end \
    end
module cis_core_irq_tb_top;
    logic        clk = 1'b0, rst = 1'b1;
    logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic [7:0]  wb_adr = 8'h00;
    logic [31:0] wb_dat = 32'h0, wb_rdat;
    logic        wb_ack, pin = 1'b0, wdt = 1'b0, slow = 1'b1, scmd = 1'b0;
    logic [3:0]  port = 4'h0;
    logic        sleep, ret, irq_req, vector, wake, sleeping, int_line;
    logic [12:0] pc;
    logic [7:0]  vec_cnt, wake_cnt = 8'h00;
    int          failures = 0, samples_checked = 0, cyc_cnt = 0;

    cis_core_irq cis_core_irq_inst
    (
        .clk_i(clk), .rst_i(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF),
        .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
        .ext_irq_pin_i(pin), .upper_port_i(port), .sleep_i(sleep),
        .wdt_wake_i(wdt), .return_i(ret), .core_pc_i(pc),
        .irq_req_o(irq_req), .vector_o(vector), .wake_o(wake),
        .sleeping_o(sleeping), .int_o(int_line)
    );
    cis_core_model cis_core_model_inst
    (
        .clk_i(clk), .rst_i(rst), .vector_i(vector), .slow_i(slow),
        .sleep_cmd_i(scmd), .sleep_o(sleep), .return_o(ret), .pc_o(pc),
        .vec_cnt_o(vec_cnt)
    );

    // Clock of 100 ns and a count of wake pulses
    always #50 clk = ~clk;
    always @(posedge clk)
    begin
        if (wake === 1'b1)
            wake_cnt <= wake_cnt + 8'h01;
    end

    // Cut a hang short
    always @(posedge clk)
    begin
        cyc_cnt++;
        if (cyc_cnt == 20000)
        begin
            failures++;
            final_report();
        end
    end

    task automatic final_report;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_cyc

    // One classic cycle, held until ack is sampled
    task automatic wb_acc(input logic we, input logic [7:0] adr,
                          input logic [7:0] dat, output logic [7:0] rd);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= we;
        wb_adr <= adr;
        wb_dat <= {24'h0, dat};
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wb_ack !== 1'b1 && n < 20);
        rd = wb_rdat[7:0];
        `CIS_CHK("ack", 1'b1, wb_ack);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask : wb_acc

    task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
        logic [7:0] d;
        wb_acc(1'b1, adr, dat, d);
    endtask : wr

    task automatic rd(input logic [7:0] adr, output logic [7:0] v);
        wb_acc(1'b0, adr, 8'h00, v);
    endtask : rd

    task automatic do_sleep;
        scmd <= 1'b1;
        @(posedge clk);
        scmd <= 1'b0;
        wait_cyc(3);
    endtask : do_sleep

    task automatic pulse_pin;
        pin <= 1'b1;
        wait_cyc(4);
        pin <= 1'b0;
        wait_cyc(4);
    endtask : pulse_pin

    task automatic t_reset;
        logic [7:0] v;
        rd(cis_pkg::ADR_CTRL, v);
        `CIS_CHK("ctrl", 8'h00, v);
        rd(cis_pkg::ADR_OPT, v);
        `CIS_CHK("opt", 8'h40, v);
        rd(cis_pkg::ADR_STAT, v);
        `CIS_CHK("stat", 8'h01, v);
        rd(8'h20, v);
        `CIS_CHK("unmapped", 8'h00, v);
    endtask : t_reset

    task automatic t_ext;
        logic [7:0] v;
        pulse_pin();
        rd(cis_pkg::ADR_CTRL, v);
        `CIS_CHK("ext flag", 8'h02, v);
        `CIS_CHK("irq blocked", 1'b0, irq_req);
        wr(cis_pkg::ADR_CTRL, 8'h12);
        wait_cyc(3);
        `CIS_CHK("irq no gie", 1'b0, irq_req);
        wr(cis_pkg::ADR_CTRL, 8'h00);
        rd(cis_pkg::ADR_CTRL, v);
        `CIS_CHK("ext cleared", 8'h00, v);
        wr(cis_pkg::ADR_OPT, 8'h00);
        pin <= 1'b1;
        wait_cyc(4);
        rd(cis_pkg::ADR_CTRL, v);
        `CIS_CHK("rise ignored", 1'b0, v[1]);
        pin <= 1'b0;
        wait_cyc(4);
        rd(cis_pkg::ADR_CTRL, v);
        `CIS_CHK("fall taken", 1'b1, v[1]);
        wr(cis_pkg::ADR_OPT, 8'h40);
        wr(cis_pkg::ADR_CTRL, 8'h00);
    endtask : t_ext

    task automatic t_timer;
        logic [7:0]  v, n0;
        logic [12:0] pc0;
        slow <= 1'b1;
        wr(cis_pkg::ADR_TMR, 8'hFE);
        wait_cyc(12);
        rd(cis_pkg::ADR_CTRL, v);
        `CIS_CHK("tmr flag", 1'b1, v[2]);
        `CIS_CHK("tmr off", 1'b0, irq_req);
        wr(cis_pkg::ADR_MASK, 8'h01);
        n0  = vec_cnt;
        pc0 = pc;
        wr(cis_pkg::ADR_CTRL, 8'hA4);
        wait_cyc(4);
        `CIS_CHK("vectors", n0 + 8'h01, vec_cnt);
        rd(cis_pkg::ADR_STK, v);
        `CIS_CHK("pushed pc", pc0[7:0], v);
        rd(cis_pkg::ADR_STAT, v);
        `CIS_CHK("depth", 8'h11, v);
        rd(cis_pkg::ADR_CTRL, v);
        `CIS_CHK("gie off", 8'h24, v);
        `CIS_CHK("int set", 1'b1, int_line);
        wr(cis_pkg::ADR_EVT, 8'h01);
        wait_cyc(2);
        `CIS_CHK("int clear", 1'b0, int_line);
        wait_cyc(40);
        rd(cis_pkg::ADR_STAT, v);
        `CIS_CHK("popped", 8'h01, v);
        wr(cis_pkg::ADR_CTRL, 8'h00);
        wr(cis_pkg::ADR_MASK, 8'h00);
    endtask : t_timer

    task automatic t_port;
        logic [7:0] v, n0;
        slow <= 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            port <= port ^ (4'h1 << i);
            wait_cyc(4);
            rd(cis_pkg::ADR_CTRL, v);
            `CIS_CHK("port flag", 1'b1, v[0]);
            wr(cis_pkg::ADR_CTRL, 8'h00);
        end
        n0 = vec_cnt;
        wr(cis_pkg::ADR_CTRL, 8'h80);
        port <= port ^ 4'h8;
        wait_cyc(5);
        `CIS_CHK("port off", 1'b0, irq_req);
        `CIS_CHK("no vector", n0, vec_cnt);
        wr(cis_pkg::ADR_CTRL, 8'h89);
        wait_cyc(5);
        `CIS_CHK("port vector", n0 + 8'h01, vec_cnt);
        wr(cis_pkg::ADR_CTRL, 8'h00);
        wait_cyc(8);
    endtask : t_port

    task automatic t_sleep;
        logic [7:0] v, w0, n0;
        w0 = wake_cnt;
        n0 = vec_cnt;
        do_sleep();
        `CIS_CHK("asleep", 1'b1, sleeping);
        wr(cis_pkg::ADR_CTRL, 8'h10);
        pulse_pin();
        `CIS_CHK("late enable", 1'b1, sleeping);
        wdt <= 1'b1;
        wait_cyc(3);
        wdt <= 1'b0;
        `CIS_CHK("wdt wake", 1'b0, sleeping);
        `CIS_CHK("wakes", w0 + 8'h01, wake_cnt);
        rd(cis_pkg::ADR_EVT, v);
        `CIS_CHK("wake event", 1'b1, v[1]);
        wr(cis_pkg::ADR_CTRL, 8'h10);
        do_sleep();
        pulse_pin();
        `CIS_CHK("pin wake", w0 + 8'h02, wake_cnt);
        `CIS_CHK("no branch", n0, vec_cnt);
        wr(cis_pkg::ADR_CTRL, 8'h90);
        do_sleep();
        pulse_pin();
        wait_cyc(4);
        `CIS_CHK("wake branch", w0 + 8'h03, wake_cnt);
        `CIS_CHK("branch", n0 + 8'h01, vec_cnt);
        wr(cis_pkg::ADR_CTRL, 8'h00);
        wait_cyc(8);
        do_sleep();
        rst <= 1'b1;
        wait_cyc(2);
        rst <= 1'b0;
        wait_cyc(2);
        `CIS_CHK("reset wake", 1'b0, sleeping);
        rd(cis_pkg::ADR_STAT, v);
        `CIS_CHK("run state", 8'h01, v);
    endtask : t_sleep

    // Main sequence
    initial
    begin
        wait_cyc(5);
        rst <= 1'b0;
        t_reset();
        t_ext();
        t_timer();
        t_port();
        t_sleep();
        final_report();
    end
endmodule : cis_core_irq_tb_top
`default_nettype wire
